// [hdl/rtrs_core.sv]
// AXI4-Lite controlled execution unit for rotate-right and set-all-ones
// Summary of operation
// - Rotate opcode 010000, d bit9, a bit8
// - Rotate right one bit, bit0 wraps, no carry
// - Rotate updates only negative and zero flags
// - d=0 writes working register, d=1 file
// - a=0 access bank, a=1 bank pointer
// - a=0, extended, offset<=5Fh uses indexed mode
// - Set opcode 0110100 writes FFh, flags untouched
// - Set with a=1 uses bank pointer register
`timescale 1ns/10ps
module rtrs_core (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [11:0]      mem_addr,
  output logic             mem_rd_en,
  input  wire logic [7:0]  mem_rdata,
  output logic             mem_wr_en,
  output logic [7:0]       mem_wdata
);

  rtrs_pkg::rtrs_state_type state;
  logic        aw_have;
  logic [7:0]  aw_addr_q;
  logic        w_have;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        ext_en;
  logic [15:0] opcode;
  logic [3:0]  bank_pointer_register;
  logic [7:0]  wreg;
  logic [7:0]  status;
  logic [11:0] index_base;
  logic        unsupported;
  logic [7:0]  operand;
  logic [7:0]  result_q;
  logic        is_rotate;
  logic        is_set_all;
  logic        dest_file;
  logic [11:0] op_addr;
  logic [7:0]  result;

  rtrs_exec u_exec (
    .opcode     (opcode),
    .bank       (bank_pointer_register),
    .ext_en     (ext_en),
    .index_base (index_base),
    .operand    (operand),
    .is_rotate  (is_rotate),
    .is_set_all (is_set_all),
    .dest_file  (dest_file),
    .op_addr    (op_addr),
    .result     (result)
  );

  // Bus decode; writes while busy are refused so operands stay stable
  wire        busy       = state != rtrs_pkg::ST_IDLE;
  wire        do_write   = aw_have && w_have && !s_axi_bvalid;
  wire        wr_ok      = do_write && rtrs_pkg::rtrs_mapped(aw_addr_q) && !busy;
  wire        wr_ctrl    = wr_ok && aw_addr_q == rtrs_pkg::REG_CTRL;
  wire        wr_instr   = wr_ok && aw_addr_q == rtrs_pkg::REG_INSTR;
  wire        wr_bank    = wr_ok && aw_addr_q == rtrs_pkg::REG_BANK;
  wire        wr_wreg    = wr_ok && aw_addr_q == rtrs_pkg::REG_WREG;
  wire        wr_status  = wr_ok && aw_addr_q == rtrs_pkg::REG_STATUS;
  wire        wr_index   = wr_ok && aw_addr_q == rtrs_pkg::REG_INDEX;
  wire [31:0] ctrl_new   = rtrs_pkg::rtrs_merge({31'h0, ext_en}, w_data_q, w_strb_q);
  wire [31:0] instr_new  = rtrs_pkg::rtrs_merge({16'h0, opcode}, w_data_q, w_strb_q);
  wire [31:0] bank_new   = rtrs_pkg::rtrs_merge({28'h0, bank_pointer_register}, w_data_q, w_strb_q);
  wire [31:0] wreg_new   = rtrs_pkg::rtrs_merge({24'h0, wreg}, w_data_q, w_strb_q);
  wire [31:0] status_new = rtrs_pkg::rtrs_merge({24'h0, status}, w_data_q, w_strb_q);
  wire [31:0] index_new  = rtrs_pkg::rtrs_merge({20'h0, index_base}, w_data_q, w_strb_q);
  wire        q4_step    = ce && state == rtrs_pkg::ST_Q4;
  wire        supported  = is_rotate || is_set_all;

  // Read selection
  wire [31:0] read_word =
    (s_axi_araddr == rtrs_pkg::REG_CTRL)   ? {31'h0, ext_en} :
    (s_axi_araddr == rtrs_pkg::REG_INSTR)  ? {16'h0, opcode} :
    (s_axi_araddr == rtrs_pkg::REG_BANK)   ? {28'h0, bank_pointer_register} :
    (s_axi_araddr == rtrs_pkg::REG_WREG)   ? {24'h0, wreg} :
    (s_axi_araddr == rtrs_pkg::REG_STATUS) ? {24'h0, status} :
    (s_axi_araddr == rtrs_pkg::REG_INDEX)  ? {20'h0, index_base} :
    (s_axi_araddr == rtrs_pkg::REG_STATE)  ? {30'h0, unsupported, busy} : 32'h0000_0000;

  // Flag update: only N and Z change after a rotate
  wire [7:0] next_status = {status[7:rtrs_pkg::STATUS_N + 1], result_q[7],
                            status[rtrs_pkg::STATUS_N - 1:rtrs_pkg::STATUS_Z + 1],
                            result_q == rtrs_pkg::ZERO_BYTE, status[rtrs_pkg::STATUS_Z - 1:0]};

  // Write address and data channels, taken in either order
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      aw_have       <= 1'b0;
      w_have        <= 1'b0;
      aw_addr_q     <= 8'h00;
      w_data_q      <= 32'h0000_0000;
      w_strb_q      <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have       <= 1'b1;
        aw_addr_q     <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have       <= 1'b1;
        w_data_q     <= s_axi_wdata;
        w_strb_q     <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        aw_have       <= 1'b0;
        w_have        <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Write response; unmapped or busy writes answer SLVERR
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= rtrs_pkg::RESP_OKAY;
    end else if (ce) begin
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? rtrs_pkg::RESP_OKAY : rtrs_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read channel, one outstanding read
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= rtrs_pkg::RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= read_word;
        s_axi_rresp   <= rtrs_pkg::rtrs_mapped(s_axi_araddr) ? rtrs_pkg::RESP_OKAY : rtrs_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid  <= 1'b0;
      end
    end
  end

  // Software configuration registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ext_en                <= 1'b0;
      bank_pointer_register <= rtrs_pkg::RST_BANK;
      index_base            <= rtrs_pkg::RST_INDEX;
      opcode                <= rtrs_pkg::RST_OPCODE;
    end else if (ce) begin
      if (wr_ctrl) ext_en <= ctrl_new[0];
      if (wr_bank) bank_pointer_register <= bank_new[3:0];
      if (wr_index) index_base <= index_new[11:0];
      if (wr_instr) opcode <= instr_new[15:0];
    end
  end

  // Working register and status: hardware owns them while busy
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wreg   <= rtrs_pkg::RST_BYTE;
      status <= rtrs_pkg::RST_BYTE;
    end else if (ce) begin
      if (q4_step && is_rotate && !dest_file) wreg <= result_q;
      else if (wr_wreg) wreg <= wreg_new[7:0];
      if (q4_step && is_rotate) status <= next_status;
      else if (wr_status) status <= status_new[7:0];
    end
  end

  // Four-phase sequencer: one instruction cycle per accepted word; an unsupported opcode returns to idle after phase one
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state       <= rtrs_pkg::ST_IDLE;
      unsupported <= 1'b0;
    end else if (ce) begin
      case (state)
        rtrs_pkg::ST_IDLE: begin
          if (wr_instr) begin
            state       <= rtrs_pkg::ST_Q1;
            unsupported <= 1'b0;
          end
        end
        rtrs_pkg::ST_Q1: begin
          state       <= supported ? rtrs_pkg::ST_Q2 : rtrs_pkg::ST_IDLE;
          unsupported <= !supported;
        end
        rtrs_pkg::ST_Q2: state <= rtrs_pkg::ST_Q3;
        rtrs_pkg::ST_Q3: state <= rtrs_pkg::ST_Q4;
        rtrs_pkg::ST_Q4: state <= rtrs_pkg::ST_IDLE;
        default: state <= rtrs_pkg::ST_IDLE;
      endcase
    end
  end

  // Data memory port: read in phase two, write in phase four
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mem_addr  <= 12'h000;
      mem_rd_en <= 1'b0;
      mem_wr_en <= 1'b0;
      mem_wdata <= rtrs_pkg::RST_BYTE;
      operand   <= rtrs_pkg::RST_BYTE;
      result_q  <= rtrs_pkg::RST_BYTE;
    end else if (ce) begin
      mem_rd_en <= state == rtrs_pkg::ST_Q1 && supported;
      if (state == rtrs_pkg::ST_Q1) mem_addr <= op_addr;
      if (state == rtrs_pkg::ST_Q2) operand <= mem_rdata;
      if (state == rtrs_pkg::ST_Q3) result_q <= result;
      mem_wr_en <= state == rtrs_pkg::ST_Q3 && (is_set_all || dest_file);
      if (state == rtrs_pkg::ST_Q3) mem_wdata <= result;
    end
  end

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence seq_q3_step;
    state == rtrs_pkg::ST_Q3 && ce;
  endsequence

  sequence seq_q4_step;
    state == rtrs_pkg::ST_Q4 && ce;
  endsequence

  AST_ROT_DECODE: assert property (state == rtrs_pkg::ST_Q1 && ce && opcode[15:10] == 6'h10 |=> state == rtrs_pkg::ST_Q2) else $error("rotate opcode not decoded");
  AST_ROT_RESULT: assert property (seq_q3_step and is_rotate |=> result_q == {operand[0], operand[7:1]}) else $error("rotate result wrong");
  AST_ROT_FLAGS: assert property (seq_q4_step and is_rotate |=> status[4] == result_q[7] && status[2] == (result_q == 8'h00) && {status[7:5], status[3], status[1:0]} == {$past(status[7:5]), $past(status[3]), $past(status[1:0])}) else $error("rotate flags wrong");
  AST_ROT_TO_W: assert property (seq_q4_step and is_rotate && !opcode[9] |=> wreg == $past(result_q) && !$past(mem_wr_en)) else $error("working register not written");
  AST_ACCESS_BANK: assert property (state == rtrs_pkg::ST_Q2 && !opcode[8] && !(ext_en && opcode[7:0] <= 8'h5F) |-> mem_addr == ((opcode[7:0] < 8'h60) ? {4'h0, opcode[7:0]} : {4'hF, opcode[7:0]})) else $error("access bank address wrong");
  AST_INDEXED: assert property (state == rtrs_pkg::ST_Q2 && !opcode[8] && ext_en && opcode[7:0] <= 8'h5F |-> mem_addr == index_base + {4'h0, opcode[7:0]}) else $error("indexed address wrong");
  AST_SET_WRITE: assert property (seq_q3_step and is_set_all |=> mem_wr_en && mem_wdata == 8'hFF ##1 status == $past(status)) else $error("set-all-ones write wrong");
  AST_BANKED: assert property (state == rtrs_pkg::ST_Q2 && opcode[8] |-> mem_addr == {bank_pointer_register, opcode[7:0]}) else $error("banked address wrong");
  AST_ONE_CYCLE: assert property (seq_q4_step |=> state == rtrs_pkg::ST_IDLE) else $error("instruction cycle overran");
  AST_PHASES: assert property (state == rtrs_pkg::ST_Q2 |-> mem_rd_en && !mem_wr_en) else $error("read not in phase two");

endmodule

// [common/rtrs_pkg.sv]
// Constants, types and helpers shared by the rotate and set-all-ones datapath
package rtrs_pkg;

  // Opcode fields
  localparam logic [5:0]  OP_ROTATE       = 6'h10;  // Upper bits 15..10 of rotate_right_no_carry
  localparam logic [6:0]  OP_SET_ALL      = 7'h34;  // Upper bits 15..9 of set_byte_all_ones
  localparam int          OP_ROT_MSB      = 15;
  localparam int          OP_ROT_LSB      = 10;
  localparam int          OP_SET_LSB      = 9;
  localparam int          BIT_DEST        = 9;
  localparam int          BIT_BANK_SEL    = 8;
  localparam int          FILE_MSB        = 7;

  // Addressing
  localparam logic [7:0]  ILO_LIMIT       = 8'h5F;  // Highest offset using indexed literal mode
  localparam logic [7:0]  ACCESS_SPLIT    = 8'h60;  // Access bank low/high boundary
  localparam logic [3:0]  ACCESS_LOW_BANK = 4'h0;
  localparam logic [3:0]  ACCESS_HI_BANK  = 4'hF;
  localparam logic [7:0]  ALL_ONES        = 8'hFF;
  localparam logic [7:0]  ZERO_BYTE       = 8'h00;

  // Core status byte bit positions
  localparam int          STATUS_Z        = 2;
  localparam int          STATUS_N        = 4;

  // Register byte offsets
  localparam logic [7:0]  REG_CTRL        = 8'h00;
  localparam logic [7:0]  REG_INSTR       = 8'h04;
  localparam logic [7:0]  REG_BANK        = 8'h08;
  localparam logic [7:0]  REG_WREG        = 8'h0C;
  localparam logic [7:0]  REG_STATUS      = 8'h10;
  localparam logic [7:0]  REG_INDEX       = 8'h14;
  localparam logic [7:0]  REG_STATE       = 8'h18;

  // Reset values
  localparam logic [7:0]  RST_BYTE        = 8'h00;
  localparam logic [3:0]  RST_BANK        = 4'h0;
  localparam logic [11:0] RST_INDEX       = 12'h000;
  localparam logic [15:0] RST_OPCODE      = 16'h0000;

  // Bus answers
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  typedef enum logic [2:0] {ST_IDLE, ST_Q1, ST_Q2, ST_Q3, ST_Q4} rtrs_state_type;

  // Byte-lane merge for register writes
  function automatic logic [31:0] rtrs_merge(input logic [31:0] old_val,
                                             input logic [31:0] new_val,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_val[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Mapped register check, used by read and write decode
  function automatic logic rtrs_mapped(input logic [7:0] addr);
    return (addr == REG_CTRL) || (addr == REG_INSTR) || (addr == REG_BANK) || (addr == REG_WREG) ||
           (addr == REG_STATUS) || (addr == REG_INDEX) || (addr == REG_STATE);
  endfunction

endpackage

// [hdl/rtrs_exec.sv]
// Opcode decode, operand address selection and rotate result
`timescale 1ns/10ps
module rtrs_exec (
  input  wire logic [15:0] opcode,
  input  wire logic [3:0]  bank,
  input  wire logic        ext_en,
  input  wire logic [11:0] index_base,
  input  wire logic [7:0]  operand,
  output logic             is_rotate,
  output logic             is_set_all,
  output logic             dest_file,
  output logic [11:0]      op_addr,
  output logic [7:0]       result
);

  logic [7:0]  file_off;
  logic        use_bank;
  logic        use_ilo;
  logic [11:0] access_addr;
  logic [11:0] banked_addr;
  logic [11:0] ilo_addr;
  logic [7:0]  rotated;

  // Opcode field decode
  assign is_rotate  = opcode[rtrs_pkg::OP_ROT_MSB:rtrs_pkg::OP_ROT_LSB] == rtrs_pkg::OP_ROTATE;
  assign is_set_all = opcode[rtrs_pkg::OP_ROT_MSB:rtrs_pkg::OP_SET_LSB] == rtrs_pkg::OP_SET_ALL;
  assign dest_file  = opcode[rtrs_pkg::BIT_DEST];
  assign use_bank   = opcode[rtrs_pkg::BIT_BANK_SEL];
  assign file_off   = opcode[rtrs_pkg::FILE_MSB:0];

  // Address candidates; indexed mode takes precedence over the access bank
  assign use_ilo     = !use_bank && ext_en && (file_off <= rtrs_pkg::ILO_LIMIT);
  assign access_addr = (file_off < rtrs_pkg::ACCESS_SPLIT) ? {rtrs_pkg::ACCESS_LOW_BANK, file_off}
                                                           : {rtrs_pkg::ACCESS_HI_BANK, file_off};
  assign banked_addr = {bank, file_off};
  assign ilo_addr    = index_base + {4'h0, file_off};
  assign op_addr     = use_ilo ? ilo_addr : (use_bank ? banked_addr : access_addr);

  // Rotate right: bit n+1 into n, bit 0 wraps to bit 7
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_rot
      assign rotated[i] = operand[(i + 1) % 8];
    end
  endgenerate

  assign result = is_set_all ? rtrs_pkg::ALL_ONES : rotated;

endmodule

// [tb/tb_rtrs_core.sv]
// Self-checking bench for the rotate and set-all-ones execution unit
`timescale 1ns/10ps
module tb_rtrs_core;
  logic        clock;
  logic        rst_n;
  logic        ce;
  logic [7:0]  s_axi_awaddr;
  logic        s_axi_awvalid;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_wvalid;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready;
  logic [7:0]  s_axi_araddr;
  logic        s_axi_arvalid;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready;
  logic [11:0] mem_addr;
  logic        mem_rd_en;
  logic [7:0]  mem_rdata;
  logic        mem_wr_en;
  logic [7:0]  mem_wdata;
  logic [7:0]  mem [4096];
  logic [7:0]  junk;
  logic [11:0] rd_a;
  int          rd_t;
  int          wr_t;
  int          wr_n;
  int          cyc;
  int          err_count;
  int          total_checks;

  rtrs_core dut (.clock(clock), .rst_n(rst_n), .ce(ce), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .mem_addr(mem_addr), .mem_rd_en(mem_rd_en), .mem_rdata(mem_rdata),
    .mem_wr_en(mem_wr_en), .mem_wdata(mem_wdata));

  // Clock, 20 ns period
  always #10 clock = ~clock;

  // Memory answers only while read enabled; otherwise a changing pattern so stale data cannot pass
  assign mem_rdata = mem_rd_en ? mem[mem_addr] : junk;

  // Memory model, phase recorder and timeout
  always @(posedge clock) begin
    cyc <= cyc + 1;
    junk <= ~junk;
    if (mem_rd_en) begin
      rd_a <= mem_addr;
      rd_t <= cyc;
    end
    if (mem_wr_en) begin
      mem[mem_addr] <= mem_wdata;
      wr_t <= cyc;
      wr_n <= wr_n + 1;
    end
    if (cyc == 20000) begin
      err_count++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks=%0d errors=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t resp got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Write cycle: address and data offered together, each dropped when taken
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge clock);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
    // Let an edge pass so a following call never re-drives the same signal in this step
    @(posedge clock);
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge clock);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
    // Let an edge pass so a following call never re-drives the same signal in this step
    @(posedge clock);
  endtask

  task automatic wr_ok(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_write(a, d, r);
    check_resp(r, rtrs_pkg::RESP_OKAY);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    axi_read(a, d, r);
    check_resp(r, rtrs_pkg::RESP_OKAY);
    check_val(d, exp);
  endtask

  // Expected operand address from bank bit, offset, bank pointer and indexed mode
  function automatic logic [11:0] exp_addr(logic a, logic [7:0] f, logic [3:0] b, logic x, logic [11:0] ix);
    if (a) return {b, f};
    if (x && f <= 8'h5F) return ix + {4'h0, f};
    return (f < 8'h60) ? {4'h0, f} : {4'hF, f};
  endfunction

  // Launch one instruction, poll busy with a bound, then check address and phase spacing
  task automatic run_op(input logic [15:0] op, input logic [11:0] adr, input int writes);
    logic [31:0] d;
    logic [1:0]  r;
    int          n0;
    n0 = wr_n;
    wr_ok(rtrs_pkg::REG_INSTR, {16'h0000, op});
    for (int i = 0; i < 20; i++) begin
      axi_read(rtrs_pkg::REG_STATE, d, r);
      if (d[0] === 1'b0) break;
    end
    check_val(d, 32'h0000_0000);
    check_val(rd_a, adr);
    check_val(wr_n - n0, writes);
    if (writes == 1) check_val(wr_t - rd_t, 2);
  endtask

  // Rotate with given destination and bank bits; flags other than N and Z must survive
  task automatic test_rotate(logic d, logic a, logic [7:0] f, logic [3:0] b, logic x, logic [7:0] src);
    logic [11:0] adr;
    logic [7:0]  res;
    adr = exp_addr(a, f, b, x, 12'h3A0);
    res = {src[0], src[7:1]};
    wr_ok(rtrs_pkg::REG_CTRL, {31'h0, x});
    wr_ok(rtrs_pkg::REG_BANK, {28'h0, b});
    wr_ok(rtrs_pkg::REG_INDEX, 32'h0000_03A0);
    wr_ok(rtrs_pkg::REG_WREG, 32'h0000_0066);
    wr_ok(rtrs_pkg::REG_STATUS, 32'h0000_00EF);
    mem[adr] = src;
    run_op({rtrs_pkg::OP_ROTATE, d, a, f}, adr, d ? 1 : 0);
    check_val(mem[adr], d ? res : src);
    rd_chk(rtrs_pkg::REG_WREG, {24'h0, d ? 8'h66 : res});
    rd_chk(rtrs_pkg::REG_STATUS, {24'h0, 3'h7, res[7], 1'b1, res == 8'h00, 2'h3});
  endtask

  // Set-all-ones writes FFh, leaves working register and status alone
  task automatic test_set(logic a, logic [7:0] f, logic [3:0] b, logic x);
    logic [11:0] adr;
    adr = exp_addr(a, f, b, x, 12'h3A0);
    wr_ok(rtrs_pkg::REG_CTRL, {31'h0, x});
    wr_ok(rtrs_pkg::REG_BANK, {28'h0, b});
    wr_ok(rtrs_pkg::REG_STATUS, 32'h0000_0014);
    wr_ok(rtrs_pkg::REG_WREG, 32'h0000_0066);
    mem[adr] = 8'h5A;
    run_op({rtrs_pkg::OP_SET_ALL, a, f}, adr, 1);
    check_val(mem[adr], 8'hFF);
    rd_chk(rtrs_pkg::REG_STATUS, 32'h0000_0014);
    rd_chk(rtrs_pkg::REG_WREG, 32'h0000_0066);
  endtask

  // Reset values, unmapped access, unsupported opcode and a write while busy
  task automatic test_refuse();
    logic [31:0] d;
    logic [1:0]  r;
    int          n0;
    rd_chk(rtrs_pkg::REG_STATE, 32'h0);
    rd_chk(rtrs_pkg::REG_WREG, 32'h0);
    axi_read(8'h1C, d, r);
    check_resp(r, rtrs_pkg::RESP_SLVERR);
    check_val(d, 32'h0);
    axi_write(8'h20, 32'h1, r);
    check_resp(r, rtrs_pkg::RESP_SLVERR);
    n0 = wr_n;
    wr_ok(rtrs_pkg::REG_INSTR, 32'h0000_4C10);
    rd_chk(rtrs_pkg::REG_STATE, 32'h0000_0002);
    check_val(wr_n - n0, 0);
    mem[12'h010] = 8'h0C;
    wr_ok(rtrs_pkg::REG_INSTR, {16'h0, rtrs_pkg::OP_ROTATE, 2'h1, 8'h10});
    axi_write(rtrs_pkg::REG_WREG, 32'h0000_0011, r);
    check_resp(r, rtrs_pkg::RESP_SLVERR);
    repeat (6) @(posedge clock);
    rd_chk(rtrs_pkg::REG_WREG, 32'h0000_0006);
  endtask

  // Clock enable low freezes the sequencer; the phase-four write waits for it
  task automatic test_freeze();
    int n0;
    wr_ok(rtrs_pkg::REG_BANK, 32'h0000_0001);
    mem[12'h144] = 8'h00;
    n0 = wr_n;
    wr_ok(rtrs_pkg::REG_INSTR, {16'h0, rtrs_pkg::OP_SET_ALL, 1'b1, 8'h44});
    ce <= 1'b0;
    repeat (8) @(posedge clock);
    check_val(wr_n - n0, 0);
    ce <= 1'b1;
    repeat (4) @(posedge clock);
    check_val(wr_n - n0, 1);
    check_val(mem[12'h144], 8'hFF);
  endtask

  initial begin
    clock = 1'b0;
    rst_n = 1'b0;
    ce = 1'b1;
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    junk = 8'h5A;
    {cyc, wr_n, rd_t, wr_t, err_count, total_checks} = '0;
    rd_a = 12'h000;
    for (int i = 0; i < 4096; i++) mem[i] = 8'h00;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    test_refuse();
    test_rotate(1'b1, 1'b1, 8'h10, 4'h2, 1'b0, 8'hD7);
    test_rotate(1'b0, 1'b0, 8'h81, 4'h2, 1'b0, 8'h01);
    test_rotate(1'b1, 1'b0, 8'h20, 4'h7, 1'b0, 8'h00);
    test_rotate(1'b0, 1'b0, 8'h5F, 4'h7, 1'b1, 8'hAA);
    test_set(1'b1, 8'h33, 4'h5, 1'b1);
    test_set(1'b0, 8'h5F, 4'h5, 1'b1);
    test_set(1'b0, 8'h60, 4'h5, 1'b1);
    test_set(1'b0, 8'h5F, 4'h5, 1'b0);
    test_freeze();
    test_done();
  end
endmodule
